// ===== hdl/acl_rule_match_config.sv
/*
  Register bank for the comparison options and first two MAC bytes of one
  access-control rule entry per port, reached through the indirect
  table-select / offset / data byte window.
  Assumes a synchronous register port on the switch system clock with
  one-cycle write strobe and registered read data.
*/
`timescale 1ns/100ps
// Summary of operation
// - Protocol mode: enable code 00 compares protocol, 11 TCP sequence
// - Protocol mode: enable codes 01 and 10 both compare TCP/UDP ports
// - Bit 1 picks destination (0) or source (1) address; resets 0
// - Bit 0: 0 matches on differ, 1 matches on equal; resets 0
// - Table field 010 in select bits 7:5 routes window to rule table
// - Port number 1..5 in select bits 3:0 picks that port's entry
// - Offset register picks entry byte; data register reads/writes it
// - Offset 0x02 holds MAC bits 47:40, read/write, resets to zero
// - Rule mode 00 disables the rule, no action taken
module acl_rule_match_config (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        srst,
  // Register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  // Rule configuration of the port chosen by sel_port
  input  wire logic [2:0]                  sel_port,
  output logic [1:0]                       rule_mode,
  output rule_cfg_pkg::compare_sel_t       compare_sel,
  output logic                             use_source_addr,
  output logic                             match_on_equal,
  output logic                             rule_active,
  output logic [15:0]                      match_mac_address_hi
);

  localparam int NP = rule_cfg_pkg::NUM_PORTS;

  logic [7:0] table_sel_r;
  logic [7:0] offset_r;
  logic [7:0] mode_ctrl_r [NP];
  logic [7:0] mac_b5_r    [NP];
  logic [7:0] mac_b4_r    [NP];
  logic [7:0] rdata_nxt;
  logic       win_hit;
  logic [2:0] win_idx;
  logic [7:0] cur_ctrl;
  logic [2:0] sel_idx;
  logic [1:0] dec_mode;
  logic [1:0] cur_enable;
  rule_cfg_pkg::compare_sel_t dec_sel;
  logic       dec_active;

  // --------------------------------------------------------------
  // Window decode
  // --------------------------------------------------------------

  // Port number to array index; out-of-range ports give no hit
  function automatic logic [2:0] port_index(input logic [3:0] port);
    logic [3:0] d;
    d = port - rule_cfg_pkg::PORT_FIRST;
    return d[2:0];
  endfunction

  function automatic logic port_valid(input logic [3:0] port);
    return port >= rule_cfg_pkg::PORT_FIRST &&
           port <= rule_cfg_pkg::PORT_LAST;
  endfunction

  // Window only reaches entries when rule table and valid port chosen
  assign win_hit = (table_sel_r[rule_cfg_pkg::TSEL_TABLE_HI:
                                rule_cfg_pkg::TSEL_TABLE_LO]
                    == rule_cfg_pkg::TABLE_RULE) &&
                   port_valid(table_sel_r[rule_cfg_pkg::TSEL_PORT_HI:
                                          rule_cfg_pkg::TSEL_PORT_LO]);
  assign win_idx = port_index(table_sel_r[rule_cfg_pkg::TSEL_PORT_HI:
                                          rule_cfg_pkg::TSEL_PORT_LO]);

  // --------------------------------------------------------------
  // Direct select registers
  // --------------------------------------------------------------

  // Table/port select and offset are plain read/write bytes
  always_ff @(posedge clock) begin
    if (srst) begin
      table_sel_r <= rule_cfg_pkg::RST_BYTE;
      offset_r    <= rule_cfg_pkg::RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == rule_cfg_pkg::ADDR_TABLE_SEL)
        table_sel_r <= reg_wdata;
      if (reg_addr == rule_cfg_pkg::ADDR_OFFSET)
        offset_r <= reg_wdata;
    end
  end

  // --------------------------------------------------------------
  // Entry storage
  // --------------------------------------------------------------

  // Only the addressed byte of the addressed port is written
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NP; i++) begin
        mode_ctrl_r[i] <= rule_cfg_pkg::RST_BYTE;
        mac_b5_r[i]    <= rule_cfg_pkg::RST_BYTE;
        mac_b4_r[i]    <= rule_cfg_pkg::RST_BYTE;
      end
    end else if (reg_wr && reg_addr == rule_cfg_pkg::ADDR_DATA &&
                 win_hit) begin
      case (offset_r)
        rule_cfg_pkg::OFS_MODE_CTRL: begin
          // Top two bits are reserved and stay zero
          mode_ctrl_r[win_idx] <= reg_wdata &
                                  rule_cfg_pkg::MODE_CTRL_WMASK;
        end
        rule_cfg_pkg::OFS_MAC_B5: begin
          mac_b5_r[win_idx] <= reg_wdata;
        end
        rule_cfg_pkg::OFS_MAC_B4: begin
          mac_b4_r[win_idx] <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------

  // Unmapped addresses and offsets read as zero
  always_comb begin
    rdata_nxt = rule_cfg_pkg::RST_BYTE;
    case (reg_addr)
      rule_cfg_pkg::ADDR_TABLE_SEL: rdata_nxt = table_sel_r;
      rule_cfg_pkg::ADDR_OFFSET:    rdata_nxt = offset_r;
      rule_cfg_pkg::ADDR_DATA: begin
        if (win_hit) begin
          case (offset_r)
            rule_cfg_pkg::OFS_MODE_CTRL: rdata_nxt = mode_ctrl_r[win_idx];
            rule_cfg_pkg::OFS_MAC_B5:    rdata_nxt = mac_b5_r[win_idx];
            rule_cfg_pkg::OFS_MAC_B4:    rdata_nxt = mac_b4_r[win_idx];
            default:                     rdata_nxt = rule_cfg_pkg::RST_BYTE;
          endcase
        end
      end
      default: rdata_nxt = rule_cfg_pkg::RST_BYTE;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge clock) begin
    if (srst)
      reg_rdata <= rule_cfg_pkg::RST_BYTE;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // --------------------------------------------------------------
  // Configuration outputs for the classifier
  // --------------------------------------------------------------

  // Out-of-range port selection looks like a disabled rule
  assign sel_idx  = (sel_port < 3'(NP)) ? sel_port : 3'h0;
  assign cur_ctrl = (sel_port < 3'(NP)) ? mode_ctrl_r[sel_idx]
                                        : rule_cfg_pkg::RST_BYTE;
  assign dec_mode = cur_ctrl[rule_cfg_pkg::MODE_HI:rule_cfg_pkg::MODE_LO];
  assign cur_enable = cur_ctrl[rule_cfg_pkg::MATCH_EN_HI:
                               rule_cfg_pkg::MATCH_EN_LO];

  match_decode i_match_decode (
    .rule_mode           (dec_mode),
    .match_enable_select (cur_enable),
    .compare_sel         (dec_sel),
    .rule_active         (dec_active)
  );

  // Registered so the classifier sees glitch-free settings
  always_ff @(posedge clock) begin
    if (srst) begin
      rule_mode            <= rule_cfg_pkg::MODE_OFF;
      compare_sel          <= rule_cfg_pkg::CMP_NONE;
      use_source_addr      <= 1'b0;
      match_on_equal       <= 1'b0;
      rule_active          <= 1'b0;
      match_mac_address_hi <= 16'h0000;
    end else begin
      rule_mode            <= dec_mode;
      compare_sel          <= dec_sel;
      use_source_addr      <= cur_ctrl[rule_cfg_pkg::SIDE_BIT];
      match_on_equal       <= cur_ctrl[rule_cfg_pkg::POL_BIT];
      rule_active          <= dec_active;
      match_mac_address_hi <= (sel_port < 3'(NP))
                              ? {mac_b5_r[sel_idx], mac_b4_r[sel_idx]}
                              : 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_l34(logic [1:0] code);
    rule_mode == rule_cfg_pkg::MODE_L34 && $past(cur_enable) == code;
  endsequence

  property p_proto;
    @(posedge clock) disable iff (srst)
      s_l34(2'h0) |-> compare_sel == rule_cfg_pkg::CMP_PROTO;
  endproperty
  a_proto: assert property (p_proto) else $error("proto select");

  property p_seq;
    @(posedge clock) disable iff (srst)
      s_l34(2'h3) |-> compare_sel == rule_cfg_pkg::CMP_TCPSEQ;
  endproperty
  a_seq: assert property (p_seq) else $error("tcp seq select");

  property p_ports;
    @(posedge clock) disable iff (srst)
      (s_l34(2'h1) or s_l34(2'h2)) |-> compare_sel == rule_cfg_pkg::CMP_PORTS;
  endproperty
  a_ports: assert property (p_ports) else $error("port select");

  property p_side;
    @(posedge clock) disable iff (srst)
      ##1 use_source_addr == $past(cur_ctrl[rule_cfg_pkg::SIDE_BIT]);
  endproperty
  a_side: assert property (p_side) else $error("side bit");

  property p_pol;
    @(posedge clock) disable iff (srst)
      ##1 match_on_equal == $past(cur_ctrl[rule_cfg_pkg::POL_BIT]);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity bit");

  property p_off;
    @(posedge clock) disable iff (srst)
      rule_mode == rule_cfg_pkg::MODE_OFF |-> !rule_active;
  endproperty
  a_off: assert property (p_off) else $error("disabled rule active");

  property p_badtable;
    @(posedge clock) disable iff (srst)
      (reg_rd && reg_addr == rule_cfg_pkg::ADDR_DATA && !win_hit)
      |=> reg_rdata == rule_cfg_pkg::RST_BYTE;
  endproperty
  a_badtable: assert property (p_badtable) else $error("window leak");

  property p_wrrd;
    @(posedge clock) disable iff (srst)
      (reg_wr && reg_addr == rule_cfg_pkg::ADDR_DATA && win_hit &&
       offset_r == rule_cfg_pkg::OFS_MAC_B5)
      |=> mac_b5_r[$past(win_idx)] == $past(reg_wdata);
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("mac byte write");

  property p_keep;
    @(posedge clock) disable iff (srst)
      // Writes to other ports or refused windows must leave port 1 alone
      !(reg_wr && reg_addr == rule_cfg_pkg::ADDR_DATA && win_hit &&
        win_idx == 3'h0)
      |=> $stable(mac_b5_r[0]) && $stable(mode_ctrl_r[0]) &&
          $stable(mac_b4_r[0]);
  endproperty
  a_keep: assert property (p_keep) else $error("stray write");

endmodule

// ===== hdl/match_decode.sv
/*
  Decodes one rule's mode/compare byte into the comparison selection
  for the layer 3/4 protocol mode.
  Assumes it is fed from registered configuration on the same clock.
*/
`timescale 1ns/100ps
module match_decode (
  // Configuration byte fields
  input  wire logic [1:0]                 rule_mode,
  input  wire logic [1:0]                 match_enable_select,
  // Decoded selection
  output rule_cfg_pkg::compare_sel_t      compare_sel,
  output logic                            rule_active
);

  // Protocol-mode decode; 01 and 10 are deliberately the same
  always_comb begin
    rule_active = (rule_mode != rule_cfg_pkg::MODE_OFF);
    compare_sel = rule_cfg_pkg::CMP_OTHER;
    case (rule_mode)
      rule_cfg_pkg::MODE_OFF: begin
        compare_sel = rule_cfg_pkg::CMP_NONE;
      end
      rule_cfg_pkg::MODE_L34: begin
        case (match_enable_select)
          2'h0:    compare_sel = rule_cfg_pkg::CMP_PROTO;
          2'h1:    compare_sel = rule_cfg_pkg::CMP_PORTS;
          2'h2:    compare_sel = rule_cfg_pkg::CMP_PORTS;
          default: compare_sel = rule_cfg_pkg::CMP_TCPSEQ;
        endcase
      end
      default: begin
        compare_sel = rule_cfg_pkg::CMP_OTHER;
      end
    endcase
  end

endmodule

// ===== hdl/rule_cfg_pkg.sv
/*
  Constants for the per-port access-control rule entry register bank:
  direct register addresses, indirect field layouts, entry byte offsets,
  rule mode and compare-select encodings, reset values.
  Assumes a single switch system clock and synchronous reset.
*/
package rule_cfg_pkg;

  // --------------------------------------------------------------
  // Direct register addresses
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_TABLE_SEL = 8'h6e;
  localparam logic [7:0] ADDR_OFFSET    = 8'h6f;
  localparam logic [7:0] ADDR_DATA      = 8'ha0;

  // --------------------------------------------------------------
  // Table-select field layout
  // --------------------------------------------------------------
  localparam int         TSEL_TABLE_HI = 7;
  localparam int         TSEL_TABLE_LO = 5;
  localparam int         TSEL_PORT_HI  = 3;
  localparam int         TSEL_PORT_LO  = 0;
  localparam logic [2:0] TABLE_RULE    = 3'h2;
  localparam logic [3:0] PORT_FIRST    = 4'h1;
  localparam logic [3:0] PORT_LAST     = 4'h5;
  localparam int         NUM_PORTS     = 5;

  // --------------------------------------------------------------
  // Entry byte offsets held here
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_MODE_CTRL = 8'h01;
  localparam logic [7:0] OFS_MAC_B5    = 8'h02;
  localparam logic [7:0] OFS_MAC_B4    = 8'h03;

  // --------------------------------------------------------------
  // Mode/compare byte field positions
  // --------------------------------------------------------------
  localparam int MODE_HI     = 5;
  localparam int MODE_LO     = 4;
  localparam int MATCH_EN_HI = 3;
  localparam int MATCH_EN_LO = 2;
  localparam int SIDE_BIT    = 1;
  localparam int POL_BIT     = 0;
  localparam logic [7:0] MODE_CTRL_WMASK = 8'h3f;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // --------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_L2    = 2'h1,
    MODE_L3    = 2'h2,
    MODE_L34   = 2'h3
  } rule_mode_t;

  typedef enum logic [2:0] {
    CMP_NONE   = 3'h0,
    CMP_PROTO  = 3'h1,
    CMP_PORTS  = 3'h2,
    CMP_TCPSEQ = 3'h3,
    CMP_OTHER  = 3'h4
  } compare_sel_t;

endpackage

// ===== verif/tb_top.sv
/*
  Self-checking bench for the rule entry register bank: reset values,
  indirect window access, refused accesses and mode/compare decode.
  Assumes the design files and package are compiled before this file.
*/
`timescale 1ns/100ps
module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                       clock = 1'b0;
  logic                       srst = 1'b1;
  logic [7:0]                 reg_addr = 8'h00;
  logic                       reg_wr = 1'b0;
  logic                       reg_rd = 1'b0;
  logic [7:0]                 reg_wdata = 8'h00;
  logic [7:0]                 reg_rdata;
  logic [2:0]                 sel_port = 3'h0;
  logic [1:0]                 rule_mode;
  rule_cfg_pkg::compare_sel_t compare_sel;
  logic                       use_source_addr;
  logic                       match_on_equal;
  logic                       rule_active;
  logic [15:0]                match_mac_address_hi;
  int                         bad_count = 0;
  int                         checks = 0;
  logic [7:0]                 d;

  // 100 MHz clock
  always #5 clock = ~clock;

  acl_rule_match_config i_acl_rule_match_config (
    .clock                (clock),
    .srst                 (srst),
    .reg_addr             (reg_addr),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .sel_port             (sel_port),
    .rule_mode            (rule_mode),
    .compare_sel          (compare_sel),
    .use_source_addr      (use_source_addr),
    .match_on_equal       (match_on_equal),
    .rule_active          (rule_active),
    .match_mac_address_hi (match_mac_address_hi)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
               exp);
    end
  endtask

  // Strobes rise and fall on falling edges, so each is seen once
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  // Data is sampled a full cycle late; it holds until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask

  task automatic sel(input logic [2:0] tbl, input logic [3:0] p,
                     input logic [7:0] ofs);
    wr(rule_cfg_pkg::ADDR_TABLE_SEL, {tbl, 1'b0, p});
    wr(rule_cfg_pkg::ADDR_OFFSET, ofs);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // All entry bytes of all ports clear after reset
  task automatic t_reset;
    for (int p = 1; p <= 5; p++) begin
      for (int o = 1; o <= 3; o++) begin
        sel(3'b010, 4'(p), 8'(o));
        rd(rule_cfg_pkg::ADDR_DATA, d);
        chk({8'h00, d}, 16'h0000, "reset byte");
      end
    end
    chk({15'h0, use_source_addr}, 16'h0000, "side reset");
    chk({15'h0, match_on_equal}, 16'h0000, "polarity reset");
    $display("test reset done");
  endtask

  // Write through the window, read back, see it at the outputs
  task automatic t_walk;
    sel(3'b010, 4'h1, 8'h02);
    wr(rule_cfg_pkg::ADDR_DATA, 8'h5a);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h005a, "mac byte5");
    sel(3'b010, 4'h1, 8'h03);
    wr(rule_cfg_pkg::ADDR_DATA, 8'hc3);
    sel_port = 3'h0;
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h00c3, "mac byte4");
    chk(match_mac_address_hi, 16'h5ac3, "mac out");
    sel_port = 3'h5;
    @(negedge clock);
    chk(match_mac_address_hi, 16'h0000, "no port");
    sel(3'b010, 4'h2, 8'h02);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "other port");
    sel(3'b010, 4'h1, 8'h01);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "other byte");
    $display("test walk done");
  endtask

  // Wrong table, ports out of range, bad offset, unmapped address
  task automatic t_refuse;
    sel(3'b011, 4'h1, 8'h02);
    wr(rule_cfg_pkg::ADDR_DATA, 8'hff);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "wrong table");
    sel(3'b010, 4'h0, 8'h02);
    wr(rule_cfg_pkg::ADDR_DATA, 8'hff);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "port 0");
    sel(3'b010, 4'h6, 8'h02);
    wr(rule_cfg_pkg::ADDR_DATA, 8'hff);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "port 6");
    sel(3'b010, 4'h1, 8'h04);
    wr(rule_cfg_pkg::ADDR_DATA, 8'hff);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "offset 4");
    rd(rule_cfg_pkg::ADDR_OFFSET, d);
    chk({8'h00, d}, 16'h0004, "offset reg");
    rd(8'h55, d);
    chk({8'h00, d}, 16'h0000, "unmapped");
    sel(3'b010, 4'h1, 8'h02);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h005a, "kept byte");
    $display("test refuse done");
  endtask

  // Every mode and enable code on port 3, seen on sel_port 2
  task automatic t_decode;
    logic [2:0] ec;
    logic [7:0] v;
    sel_port = 3'h2;
    sel(3'b010, 4'h3, 8'h01);
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 4; e++) begin
        v = {2'b11, 2'(m), 2'(e), 1'(m ^ e), 1'(e >> 1)};
        wr(rule_cfg_pkg::ADDR_DATA, v);
        rd(rule_cfg_pkg::ADDR_DATA, d);
        chk({8'h00, d}, {8'h00, v & 8'h3f}, "mode byte");
        if (m == 0) ec = rule_cfg_pkg::CMP_NONE;
        else if (m != 3) ec = rule_cfg_pkg::CMP_OTHER;
        else if (e == 0) ec = rule_cfg_pkg::CMP_PROTO;
        else if (e == 3) ec = rule_cfg_pkg::CMP_TCPSEQ;
        else ec = rule_cfg_pkg::CMP_PORTS;
        chk({13'h0, compare_sel}, {13'h0, ec}, "compare");
        chk({14'h0, rule_mode}, 16'(m), "mode");
        chk({15'h0, rule_active}, 16'(m != 0), "active");
        chk({15'h0, use_source_addr}, {15'h0, v[1]}, "side");
        chk({15'h0, match_on_equal}, {15'h0, v[0]}, "polarity");
      end
    end
    $display("test decode done");
  endtask

  // Reset in mid-run clears outputs and stored bytes again
  task automatic t_rerst;
    @(negedge clock);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    chk({15'h0, match_on_equal}, 16'h0000, "polarity rerst");
    chk({15'h0, rule_active}, 16'h0000, "active rerst");
    chk({13'h0, compare_sel}, {13'h0, rule_cfg_pkg::CMP_NONE},
        "compare rerst");
    sel(3'b010, 4'h1, 8'h02);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "mac rerst");
    sel(3'b010, 4'h3, 8'h01);
    rd(rule_cfg_pkg::ADDR_DATA, d);
    chk({8'h00, d}, 16'h0000, "mode rerst");
    $display("test rerst done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    t_reset();
    t_walk();
    t_refuse();
    t_decode();
    t_rerst();
    finish_test();
  end

  // A hang costs a mismatch and ends the run
  initial begin
    repeat (50000) @(posedge clock);
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    finish_test();
  end
endmodule
